// ---- src/pim_pkg.sv ----
// Constants of the peripheral identifier map: identifier numbers, masks and reset values.
// Assumes one master clock and a synchronous system reset shared by every user.
package pim_pkg;

    // =========================================================================
    // Identifier space
    // =========================================================================
    localparam int NUM_IDS = 32;

    localparam int ID_FAST_IRQ    = 0;
    localparam int ID_SYS_GROUP   = 1;
    localparam int ID_IO_PORT_A   = 2;
    localparam int ID_IO_PORT_B   = 3;
    localparam int ID_IO_PORT_C   = 4;
    localparam int ID_ANALOG_CONV = 5;
    localparam int ID_SERIAL_0    = 6;
    localparam int ID_SERIAL_1    = 7;
    localparam int ID_SERIAL_2    = 8;
    localparam int ID_CARD_HOST   = 9;
    localparam int ID_USB_DEVICE  = 10;
    localparam int ID_TWO_WIRE    = 11;
    localparam int ID_SPI_0       = 12;
    localparam int ID_SPI_1       = 13;
    localparam int ID_SYNC_SERIAL = 14;
    localparam int ID_UNUSED_0    = 15;
    localparam int ID_UNUSED_1    = 16;
    localparam int ID_TIMER_0     = 17;
    localparam int ID_TIMER_1     = 18;
    localparam int ID_TIMER_2     = 19;
    localparam int ID_USB_HOST    = 20;
    localparam int ID_ETHERNET    = 21;
    localparam int ID_IMAGE       = 22;
    localparam int ID_SERIAL_3    = 23;
    localparam int ID_SERIAL_4    = 24;
    localparam int ID_SERIAL_5    = 25;
    localparam int ID_TIMER_3     = 26;
    localparam int ID_TIMER_4     = 27;
    localparam int ID_TIMER_5     = 28;
    localparam int ID_EXT_IRQ_0   = 29;
    localparam int ID_EXT_IRQ_1   = 30;
    localparam int ID_EXT_IRQ_2   = 31;

    // =========================================================================
    // Masks and reset values
    // =========================================================================
    // Identifiers whose clock enable bit really gates a clock.
    localparam logic [31:0] CLK_GATED_MASK = 32'h1fee_7ffc;
    // Identifiers whose interrupt source is wired to a requester.
    localparam logic [31:0] IRQ_USED_MASK  = 32'hfffe_7fff;
    localparam logic [31:0] CLK_EN_RESET   = 32'h0000_0000;
    localparam logic [31:0] IRQ_SRC_RESET  = 32'h0000_0000;
    localparam logic        SYS_CLK_RESET  = 1'b1;

endpackage

// ---- src/pim_clk_slot.sv ----
// One peripheral clock enable bit driven by set and clear write strobes.
// Assumes the strobes are one-cycle pulses synchronous to clk.
module pim_clk_slot
    import pim_pkg::*;
#(
    parameter logic GATED = 1'b1
)(
    // Clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // Write strobes for this bit
    input  wire logic set_hit,
    input  wire logic clr_hit,
    // Enable state
    output logic      en_q
);

    logic en_d;

    // Next enable; set wins when both strobes land together, so no set request is lost.
    always_comb
    begin
        en_d = en_q;
        if (!GATED)
        begin
            en_d = 1'b0;
        end
        else if (set_hit)
        begin
            en_d = 1'b1;
        end
        else if (clr_hit)
        begin
            en_d = 1'b0;
        end
    end

    // Register the enable.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            en_q <= CLK_EN_RESET[0];
        end
        else
        begin
            en_q <= en_d;
        end
    end

endmodule

// ---- src/pim_id_map.sv ----
// Peripheral identifier map: gathers interrupt requests into the 32 sources of the
// vectored interrupt controller and holds the 32 peripheral clock enable bits.
// Assumes requests are levels synchronous to clk and clock writes are one-cycle pulses.
module pim_id_map
    import pim_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // External interrupt pins
    input  wire logic        fast_irq_pin,
    input  wire logic        ext_irq_pin_0,
    input  wire logic        ext_irq_pin_1,
    input  wire logic        ext_irq_pin_2,
    // System unit group requests
    input  wire logic        mem_ctrl_irq,
    input  wire logic        debug_serial_irq,
    input  wire logic        interval_timer_irq,
    input  wire logic        rt_timer_irq,
    input  wire logic        watchdog_irq,
    input  wire logic        reset_ctrl_irq,
    input  wire logic        power_clock_manager_irq,
    // Peripheral requests
    input  wire logic        io_port_a_irq,
    input  wire logic        io_port_b_irq,
    input  wire logic        io_port_c_irq,
    input  wire logic        analog_conv_irq,
    input  wire logic        serial_port_0_irq,
    input  wire logic        serial_port_1_irq,
    input  wire logic        serial_port_2_irq,
    input  wire logic        memory_card_host_irq,
    input  wire logic        usb_device_port_irq,
    input  wire logic        two_wire_port_irq,
    input  wire logic        spi_port_0_irq,
    input  wire logic        spi_port_1_irq,
    input  wire logic        sync_serial_ctrl_irq,
    input  wire logic        timer_counter_0_irq,
    input  wire logic        timer_counter_1_irq,
    input  wire logic        timer_counter_2_irq,
    input  wire logic        usb_host_port_irq,
    input  wire logic        ethernet_ctrl_irq,
    input  wire logic        image_sensor_port_irq,
    input  wire logic        serial_port_3_irq,
    input  wire logic        serial_port_4_irq,
    input  wire logic        serial_port_5_irq,
    input  wire logic        timer_counter_3_irq,
    input  wire logic        timer_counter_4_irq,
    input  wire logic        timer_counter_5_irq,
    // Clock set and clear writes from the power clock manager
    input  wire logic        clk_set_wr,
    input  wire logic [31:0] clk_set_data,
    input  wire logic        clk_clr_wr,
    input  wire logic [31:0] clk_clr_data,
    // Interrupt sources to the vectored interrupt controller
    output logic      [31:0] irq_src_q,
    // Clock enables, bit position equals identifier
    output logic      [31:0] periph_clk_en_q,
    output logic             sys_clk_en_q
);

    // =========================================================================
    // Interrupt source gathering
    // =========================================================================
    logic [31:0] irq_src_d;
    logic        sys_group_req;

    assign sys_group_req = mem_ctrl_irq | debug_serial_irq | interval_timer_irq
                         | rt_timer_irq | watchdog_irq | reset_ctrl_irq
                         | power_clock_manager_irq;

    // Place each request on its identifier; unused slots stay low.
    always_comb
    begin
        irq_src_d                 = IRQ_SRC_RESET;
        irq_src_d[ID_FAST_IRQ]    = fast_irq_pin;
        irq_src_d[ID_EXT_IRQ_0]   = ext_irq_pin_0;
        irq_src_d[ID_EXT_IRQ_1]   = ext_irq_pin_1;
        irq_src_d[ID_EXT_IRQ_2]   = ext_irq_pin_2;
        irq_src_d[ID_SYS_GROUP]   = sys_group_req;
        irq_src_d[ID_IO_PORT_A]   = io_port_a_irq;
        irq_src_d[ID_IO_PORT_B]   = io_port_b_irq;
        irq_src_d[ID_IO_PORT_C]   = io_port_c_irq;
        irq_src_d[ID_ANALOG_CONV] = analog_conv_irq;
        irq_src_d[ID_SERIAL_0]    = serial_port_0_irq;
        irq_src_d[ID_SERIAL_1]    = serial_port_1_irq;
        irq_src_d[ID_SERIAL_2]    = serial_port_2_irq;
        irq_src_d[ID_CARD_HOST]   = memory_card_host_irq;
        irq_src_d[ID_USB_DEVICE]  = usb_device_port_irq;
        irq_src_d[ID_TWO_WIRE]    = two_wire_port_irq;
        irq_src_d[ID_SPI_0]       = spi_port_0_irq;
        irq_src_d[ID_SPI_1]       = spi_port_1_irq;
        irq_src_d[ID_SYNC_SERIAL] = sync_serial_ctrl_irq;
        irq_src_d[ID_TIMER_0]     = timer_counter_0_irq;
        irq_src_d[ID_TIMER_1]     = timer_counter_1_irq;
        irq_src_d[ID_TIMER_2]     = timer_counter_2_irq;
        irq_src_d[ID_USB_HOST]    = usb_host_port_irq;
        irq_src_d[ID_ETHERNET]    = ethernet_ctrl_irq;
        irq_src_d[ID_IMAGE]       = image_sensor_port_irq;
        irq_src_d[ID_SERIAL_3]    = serial_port_3_irq;
        irq_src_d[ID_SERIAL_4]    = serial_port_4_irq;
        irq_src_d[ID_SERIAL_5]    = serial_port_5_irq;
        irq_src_d[ID_TIMER_3]     = timer_counter_3_irq;
        irq_src_d[ID_TIMER_4]     = timer_counter_4_irq;
        irq_src_d[ID_TIMER_5]     = timer_counter_5_irq;
        irq_src_d                 = irq_src_d & IRQ_USED_MASK;
    end

    // Register the sources; costs one cycle of latency but keeps outputs glitch free.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            irq_src_q <= IRQ_SRC_RESET;
        end
        else
        begin
            irq_src_q <= irq_src_d;
        end
    end

    // =========================================================================
    // Peripheral clock enables
    // =========================================================================
    logic sys_clk_en_d;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_IDS; gi = gi + 1)
        begin : g_slot
            pim_clk_slot #(
                .GATED (CLK_GATED_MASK[gi])
            ) u_slot (
                .clk     (clk),
                .srst    (srst),
                .set_hit (clk_set_wr & clk_set_data[gi]),
                .clr_hit (clk_clr_wr & clk_clr_data[gi]),
                .en_q    (periph_clk_en_q[gi])
            );
        end
    endgenerate

    assign sys_clk_en_d = 1'b1;

    // The system unit clock has no off state; reset value matches the running value.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            sys_clk_en_q <= SYS_CLK_RESET;
        end
        else
        begin
            sys_clk_en_q <= sys_clk_en_d;
        end
    end

    // =========================================================================
    // Checks
    // =========================================================================
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    // The source checks skip the first edge after reset: the flops were
    // cleared at the previous edge, whatever the inputs showed there.
    a_sys_merge_or: assert property (
        !$past(srst) |-> irq_src_q[ID_SYS_GROUP] == $past(sys_group_req))
        else $error("System source does not follow merged requests.");

    a_fast_pin_map: assert property (
        !$past(srst) |-> irq_src_q[ID_FAST_IRQ] == $past(fast_irq_pin))
        else $error("Fast pin not seen on source zero.");

    a_ext_pin_map: assert property (
        !$past(srst) |-> irq_src_q[ID_EXT_IRQ_2:ID_EXT_IRQ_0]
            == $past({ext_irq_pin_2, ext_irq_pin_1, ext_irq_pin_0}))
        else $error("External pins not on sources 29 to 31.");

    a_io_port_map: assert property (
        !$past(srst) |-> irq_src_q[ID_IO_PORT_C:ID_IO_PORT_A]
            == $past({io_port_c_irq, io_port_b_irq, io_port_a_irq}))
        else $error("Port controllers not on sources 2 to 4.");

    a_low_ids_order: assert property (
        !$past(srst) |-> irq_src_q[ID_SYNC_SERIAL:ID_ANALOG_CONV]
            == $past({sync_serial_ctrl_irq, spi_port_1_irq, spi_port_0_irq,
                      two_wire_port_irq, usb_device_port_irq, memory_card_host_irq,
                      serial_port_2_irq, serial_port_1_irq, serial_port_0_irq,
                      analog_conv_irq}))
        else $error("Identifiers 5 to 14 out of order.");

    a_high_ids_order: assert property (
        !$past(srst) |-> irq_src_q[ID_TIMER_5:ID_TIMER_0]
            == $past({timer_counter_5_irq, timer_counter_4_irq, timer_counter_3_irq,
                      serial_port_5_irq, serial_port_4_irq, serial_port_3_irq,
                      image_sensor_port_irq, ethernet_ctrl_irq, usb_host_port_irq,
                      timer_counter_2_irq, timer_counter_1_irq, timer_counter_0_irq}))
        else $error("Identifiers 17 to 28 out of order.");

    a_unused_idle: assert property (
        !irq_src_q[ID_UNUSED_0] && !irq_src_q[ID_UNUSED_1]
        && !periph_clk_en_q[ID_UNUSED_0] && !periph_clk_en_q[ID_UNUSED_1])
        else $error("Unused identifiers are active.");

    a_fixed_ids_off: assert property (
        (periph_clk_en_q & ~CLK_GATED_MASK) == 32'h0000_0000)
        else $error("Write changed a non-gated clock bit.");

    a_set_enables: assert property (
        clk_set_wr && clk_set_data[ID_SERIAL_0] |=> periph_clk_en_q[ID_SERIAL_0])
        else $error("Clock set did not enable serial port 0.");

    a_clear_disables: assert property (
        clk_clr_wr && clk_clr_data[ID_ETHERNET] && !(clk_set_wr && clk_set_data[ID_ETHERNET])
        |=> !periph_clk_en_q[ID_ETHERNET])
        else $error("Clock clear did not disable ethernet.");

    a_sys_clk_on: assert property (
        sys_clk_en_q && !periph_clk_en_q[ID_SYS_GROUP])
        else $error("System clock off or identifier 1 gated.");

    c_sys_request: cover property (sys_group_req ##1 irq_src_q[ID_SYS_GROUP]);
    c_set_then_clear: cover property (
        periph_clk_en_q[ID_TIMER_0] ##[1:8] !periph_clk_en_q[ID_TIMER_0]);
    c_ignored_write: cover property (clk_set_wr && clk_set_data[ID_USB_HOST]);
    c_all_ext_pins: cover property (&irq_src_q[ID_EXT_IRQ_2:ID_EXT_IRQ_0]);

endmodule

// ---- verif/pim_clk_mgr_model.sv ----
// Far-side model of the peripheral clock manager: turns bench commands into write strobes.
// Assumes the bench drives commands at the rising clock edge and holds them one cycle.
module pim_clk_mgr_model
(
    // Commands from the bench
    input  wire logic        go_set,
    input  wire logic        go_clr,
    input  wire logic [31:0] wr_data,
    // Write strobes toward the identifier map
    output logic             clk_set_wr,
    output logic      [31:0] clk_set_data,
    output logic             clk_clr_wr,
    output logic      [31:0] clk_clr_data
);
    timeunit 1ns;
    timeprecision 1ps;

    // =========================================================================
    // Write strobes
    // =========================================================================
    // Idle data carries the inverse pattern, so a design that samples it
    // without a strobe cannot get lucky with a stale value.
    assign clk_set_wr   = go_set;
    assign clk_clr_wr   = go_clr;
    assign clk_set_data = go_set ? wr_data : ~wr_data;
    assign clk_clr_data = go_clr ? wr_data : ~wr_data;
endmodule

// ---- verif/pim_id_map_bench.sv ----
// Self-checking bench for the peripheral identifier map.
// Assumes one 125 MHz clock; the clock manager model drives the write side.
`define CHK(nm, ex, got) \
    begin \
        checks_done++; \
        if ((got) !== (ex)) \
        begin \
            failures++; \
            $display("MISMATCH %s expected %h seen %h", nm, ex, got); \
        end \
    end
module pim_id_map_bench
    import pim_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    // =========================================================================
    // Stimulus and observation
    // =========================================================================
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [31:0] req = 32'h0;
    logic [6:0]  sys_req = 7'h0;
    logic        go_set = 1'b0;
    logic        go_clr = 1'b0;
    logic [31:0] wr_data = 32'h0;
    logic        clk_set_wr, clk_clr_wr, sys_clk_en_q;
    logic [31:0] clk_set_data, clk_clr_data, irq_src_q, periph_clk_en_q;
    logic [31:0] irq_exp = 32'h0;
    int          failures = 0;
    int          checks_done = 0;
    int          cycles = 0;

    // Free-running clock, 8 ns period.
    initial
    begin
        forever #4 clk = ~clk;
    end

    // =========================================================================
    // Design and far-side model
    // =========================================================================
    pim_id_map pim_id_map_inst (
        .clk(clk), .srst(srst), .fast_irq_pin(req[0]), .ext_irq_pin_0(req[29]),
        .ext_irq_pin_1(req[30]), .ext_irq_pin_2(req[31]), .mem_ctrl_irq(sys_req[0]),
        .debug_serial_irq(sys_req[1]), .interval_timer_irq(sys_req[2]),
        .rt_timer_irq(sys_req[3]), .watchdog_irq(sys_req[4]), .reset_ctrl_irq(sys_req[5]),
        .power_clock_manager_irq(sys_req[6]), .io_port_a_irq(req[2]),
        .io_port_b_irq(req[3]), .io_port_c_irq(req[4]), .analog_conv_irq(req[5]),
        .serial_port_0_irq(req[6]), .serial_port_1_irq(req[7]), .serial_port_2_irq(req[8]),
        .memory_card_host_irq(req[9]), .usb_device_port_irq(req[10]),
        .two_wire_port_irq(req[11]), .spi_port_0_irq(req[12]), .spi_port_1_irq(req[13]),
        .sync_serial_ctrl_irq(req[14]), .timer_counter_0_irq(req[17]),
        .timer_counter_1_irq(req[18]), .timer_counter_2_irq(req[19]),
        .usb_host_port_irq(req[20]), .ethernet_ctrl_irq(req[21]),
        .image_sensor_port_irq(req[22]), .serial_port_3_irq(req[23]),
        .serial_port_4_irq(req[24]), .serial_port_5_irq(req[25]),
        .timer_counter_3_irq(req[26]), .timer_counter_4_irq(req[27]),
        .timer_counter_5_irq(req[28]), .clk_set_wr(clk_set_wr), .clk_set_data(clk_set_data),
        .clk_clr_wr(clk_clr_wr), .clk_clr_data(clk_clr_data), .irq_src_q(irq_src_q),
        .periph_clk_en_q(periph_clk_en_q), .sys_clk_en_q(sys_clk_en_q));

    pim_clk_mgr_model pim_clk_mgr_model_inst (
        .go_set(go_set), .go_clr(go_clr), .wr_data(wr_data), .clk_set_wr(clk_set_wr),
        .clk_set_data(clk_set_data), .clk_clr_wr(clk_clr_wr), .clk_clr_data(clk_clr_data));

    // =========================================================================
    // Helpers
    // =========================================================================
    // Identifiers whose enable bit really gates a clock.
    function automatic logic gated(input int n);
        return !(n inside {0, 1, 15, 16, 20, 29, 30, 31});
    endfunction

    // Checks the old value one step after the drive edge, so the latency is exact.
    task automatic drive_irq(input logic [31:0] r, input logic [6:0] s,
                             input logic [31:0] ex, input string nm);
        @(posedge clk);
        req     <= r;
        sys_req <= s;
        #1;
        `CHK(nm, irq_exp, irq_src_q)
        @(posedge clk);
        #1;
        `CHK(nm, ex, irq_src_q)
        irq_exp = ex;
    endtask

    task automatic wr_clk(input logic s, input logic c, input logic [31:0] d,
                          input logic [31:0] ex, input string nm);
        @(posedge clk);
        go_set  <= s;
        go_clr  <= c;
        wr_data <= d;
        @(posedge clk);
        go_set <= 1'b0;
        go_clr <= 1'b0;
        #1;
        `CHK(nm, ex, periph_clk_en_q)
        `CHK(nm, 1'b1, sys_clk_en_q)
    endtask

    // =========================================================================
    // Scenarios
    // =========================================================================
    task automatic t_irq_walk();
        logic [31:0] ex;
        for (int n = 0; n < NUM_IDS; n++)
        begin
            ex = (n == 1 || n == 15 || n == 16) ? 32'h0 : 32'h1 << n;
            drive_irq(32'h1 << n, 7'h0, ex, "irq walk");
        end
        drive_irq(32'hffff_ffff, 7'h7f, 32'hfffe_7fff, "irq all");
        for (int k = 0; k < 7; k++)
            drive_irq(32'h0, 7'h1 << k, 32'h2, "sys or");
        drive_irq(32'h0, 7'h0, 32'h0, "irq idle");
        $display("test irq map done");
    endtask

    task automatic t_clk_walk();
        logic [31:0] ex;
        for (int n = 0; n < NUM_IDS; n++)
        begin
            ex = gated(n) ? 32'h1 << n : 32'h0;
            wr_clk(1'b1, 1'b0, 32'h1 << n, ex, "clk set");
            wr_clk(1'b0, 1'b1, 32'h1 << n, 32'h0, "clk clear");
        end
        $display("test clk walk done");
    endtask

    // Writes one idle cycle apart: all bits, ungated clears, set and clear together.
    task automatic t_clk_edge();
        logic [31:0] m;
        m = 32'h0;
        for (int n = 0; n < NUM_IDS; n++)
            m[n] = gated(n);
        wr_clk(1'b1, 1'b0, 32'hffff_ffff, m, "clk all");
        wr_clk(1'b0, 1'b1, ~m, m, "clk clear ungated");
        wr_clk(1'b1, 1'b1, 32'h40, m, "set over clear");
        wr_clk(1'b0, 1'b1, 32'hffff_ffff, 32'h0, "clk none");
        $display("test clk edge done");
    endtask

    // Reset in mid-run with requests and an enable active.
    task automatic t_mid_reset();
        wr_clk(1'b1, 1'b0, 32'h40, 32'h40, "clk before reset");
        @(posedge clk);
        req     <= 32'hffff_ffff;
        sys_req <= 7'h7f;
        srst    <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        `CHK("reset irq", 32'h0, irq_src_q)
        `CHK("reset clk", 32'h0, periph_clk_en_q)
        `CHK("reset sys clk", 1'b1, sys_clk_en_q)
        @(posedge clk);
        srst    <= 1'b0;
        req     <= 32'h0;
        sys_req <= 7'h0;
        irq_exp = 32'h0;
        $display("test mid reset done");
    endtask

    // =========================================================================
    // Run control
    // =========================================================================
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // A hang is cut short well above the few hundred cycles the run needs.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            failures++;
            tally_and_finish();
        end
    end

    initial
    begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        #1;
        `CHK("init clk", 32'h0, periph_clk_en_q)
        `CHK("init sys clk", 1'b1, sys_clk_en_q)
        t_irq_walk();
        t_clk_walk();
        t_clk_edge();
        t_mid_reset();
        t_irq_walk();
        tally_and_finish();
    end
endmodule
